//--- design/svt_defs.vh
// Functional notes
// [RULE1] tuning word is bits 6:0, bit 7 reserved
// [RULE2] engine writes tuning word itself while running
// [RULE3] finished tuning word reads back, rewritable later
// [RULE4] software avoids tuning register during calibration
// [RULE5] software sets hold before reprogramming, clears after
// [RULE6] hold bit keeps synthesizer and engine reset
// [RULE7] settle field 6:4 sets per-step wait
// [RULE8] enabled engine starts when hold written zero
// [RULE9] engine centers oscillator by stepping tuning word
// [RULE10] tune control changed only while hold set; ctrl_reg accepts writes whether or not hold is set
// [RULE11] done flag set on completion or skip
// [RULE12] software writes reset values to reserved bits
// [RULE13] done flag clears whenever hold is set; code lets a completion or skip in that same cycle set it instead
// [RULE14] idle software write sets tuning value directly
`ifndef SVT_DEFS_VH
`define SVT_DEFS_VH
`define SVT_ADDR_TUNE      8'h59
`define SVT_ADDR_HOLD      8'h5c
`define SVT_ADDR_CTRL      8'h5d
`define SVT_ADDR_STAT      8'h5e
`define SVT_RST_TUNE       8'h00
`define SVT_RST_HOLD       8'h00
`define SVT_RST_CTRL       8'h40
`define SVT_TUNE_MSB       6
`define SVT_STL_MSB        6
`define SVT_STL_LSB        4
`define SVT_EN_BIT         0
`define SVT_HOLD_BIT       0
`define SVT_DONE_BIT       0
`define SVT_STEP_NS        1000
`define SVT_CLK_NS         50
`define SVT_STEP_CYC       ((`SVT_STEP_NS + `SVT_CLK_NS - 1) / `SVT_CLK_NS)
`endif

//--- design/svt_settle_timer.v
`timescale 1ns/1ps
`include "svt_defs.vh"
// ----------------------------------------
// settle timer: waits (base << sel) cycles
// ----------------------------------------
module svt_settle_timer #(
  parameter BASE_CYC = `SVT_STEP_CYC,
  parameter CNT_W    = 16
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             reset,
  // control
  input  wire             start,
  input  wire [2:0]       sel,
  output wire             expired
);
  reg  [CNT_W-1:0] count_reg;
  reg              run_reg;
  wire [CNT_W-1:0] load_val = (BASE_CYC[CNT_W-1:0] << sel) - {{(CNT_W-1){1'b0}}, 1'b1};

  assign expired = run_reg && (count_reg == {CNT_W{1'b0}});

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_reg <= {CNT_W{1'b0}};
      run_reg   <= 1'b0;
    end else if (start) begin
      count_reg <= load_val; // [RULE7]
      run_reg   <= 1'b1;
    end else if (expired) begin
      run_reg   <= 1'b0;
    end else if (run_reg) begin
      count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // svt_settle_timer

//--- design/svt_tune_cal.v
`timescale 1ns/1ps
`include "svt_defs.vh"
// ----------------------------------------
// oscillator tuning calibration sequencer
// ----------------------------------------
module svt_tune_cal #(
  parameter BASE_CYC = `SVT_STEP_CYC
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       reset,
  // register port
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // frequency comparator, asynchronous
  input  wire       osc_too_fast,
  // synthesizer side
  output reg  [6:0] oscillator_tuning_word,
  output wire       synth_reset
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE   = 4'b0001;
  localparam ST_SETTLE = 4'b0010;
  localparam ST_DECIDE = 4'b0100;
  localparam ST_DONE   = 4'b1000;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  reg  [7:0] tune_reg;
  reg        hold_reg;
  reg  [7:0] ctrl_reg;
  reg        done_reg;
  reg  [7:0] rdata_next;

  // ----------------------------------------
  // engine
  // ----------------------------------------
  reg  [3:0] state_reg;
  reg  [3:0] state_next;
  reg  [2:0] bit_reg;
  reg        fast_s1_reg;
  reg        fast_s2_reg;
  wire       expired;
  wire       timer_start;
  wire       engine_en = ctrl_reg[`SVT_EN_BIT];
  wire       busy      = (state_reg == ST_SETTLE) || (state_reg == ST_DECIDE);
  wire       last_step = (state_reg == ST_DECIDE) && (bit_reg == 3'd0);
  wire [2:0] trial_lo  = bit_reg - 3'd1;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  wire       wr_tune   = reg_wr && (reg_addr == `SVT_ADDR_TUNE);
  wire       wr_hold   = reg_wr && (reg_addr == `SVT_ADDR_HOLD);
  wire       wr_ctrl   = reg_wr && (reg_addr == `SVT_ADDR_CTRL);
  wire       release_h = wr_hold && hold_reg && !reg_wdata[`SVT_HOLD_BIT];
  wire       hold_set  = wr_hold && reg_wdata[`SVT_HOLD_BIT];
  wire       held      = hold_reg || hold_set;
  wire       eng_rst   = held && !release_h;
  wire       done_set  = (release_h && !engine_en) || last_step;

  // ----------------------------------------
  // synthesizer hold and timer start
  // ----------------------------------------
  assign synth_reset = hold_reg; // [RULE6]
  assign timer_start = !eng_rst &&
                       ((state_reg == ST_IDLE && state_next == ST_SETTLE) ||
                        (state_reg == ST_DECIDE && state_next == ST_SETTLE));

  // ----------------------------------------
  // comparator synchroniser
  // ----------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fast_s1_reg <= 1'b0;
      fast_s2_reg <= 1'b0;
    end else begin
      fast_s1_reg <= osc_too_fast;
      fast_s2_reg <= fast_s1_reg;
    end
  end

  // ----------------------------------------
  // settle timer
  // ----------------------------------------
  svt_settle_timer #(
    .BASE_CYC (BASE_CYC)
  ) u_timer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .start   (timer_start),
    .sel     (ctrl_reg[`SVT_STL_MSB:`SVT_STL_LSB]),
    .expired (expired)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (release_h && engine_en)
          state_next = ST_SETTLE; // [RULE8]
        else if (release_h)
          state_next = ST_DONE; // [RULE11]
      end
      ST_SETTLE: begin
        if (expired)
          state_next = ST_DECIDE;
      end
      ST_DECIDE: begin
        if (bit_reg == 3'd0)
          state_next = ST_DONE;
        else
          state_next = ST_SETTLE;
      end
      ST_DONE: begin
        state_next = ST_DONE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // engine state and trial bit
  // ----------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      bit_reg   <= 3'd6;
    end else if (eng_rst) begin
      state_reg <= ST_IDLE; // [RULE6]
      bit_reg   <= 3'd6;
    end else begin
      state_reg <= state_next; // [RULE8]
      if ((state_reg == ST_DECIDE) && (bit_reg != 3'd0))
        bit_reg <= trial_lo;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hold_reg <= |(`SVT_RST_HOLD & (8'h01 << `SVT_HOLD_BIT));
      ctrl_reg <= `SVT_RST_CTRL;
    end else begin
      if (wr_hold)
        hold_reg <= reg_wdata[`SVT_HOLD_BIT];
      if (wr_ctrl)
        ctrl_reg <= reg_wdata; // [RULE10]
    end
  end

  // ----------------------------------------
  // tuning word
  // ----------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tune_reg <= `SVT_RST_TUNE;
    end else if (release_h && engine_en) begin
      tune_reg <= 8'h40; // [RULE2]
    end else if ((state_reg == ST_DECIDE) && !held) begin
      // binary search: keep or drop trial bit, try next lower
      if (fast_s2_reg)
        tune_reg[bit_reg] <= 1'b0; // [RULE9]
      if (bit_reg != 3'd0)
        tune_reg[trial_lo] <= 1'b1; // [RULE2]
    end else if (wr_tune && (held || !busy)) begin
      tune_reg <= {1'b0, reg_wdata[`SVT_TUNE_MSB:0]}; // [RULE3] [RULE14]
    end
  end

  // ----------------------------------------
  // done flag: completion wins over hold clear
  // ----------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset)
      done_reg <= 1'b0;
    else if (done_set)
      done_reg <= 1'b1; // [RULE11]
    else if (held)
      done_reg <= 1'b0; // [RULE13]
  end

  // ----------------------------------------
  // tuning output
  // ----------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset)
      oscillator_tuning_word <= 7'h00;
    else
      oscillator_tuning_word <= tune_reg[`SVT_TUNE_MSB:0]; // [RULE1]
  end

  // ----------------------------------------
  // readback
  // ----------------------------------------
  always @* begin
    rdata_next = 8'h00;
    case (reg_addr)
      `SVT_ADDR_TUNE: rdata_next = {1'b0, tune_reg[`SVT_TUNE_MSB:0]}; // [RULE3]
      `SVT_ADDR_HOLD: rdata_next = {7'h00, hold_reg};
      `SVT_ADDR_CTRL: rdata_next = ctrl_reg;
      `SVT_ADDR_STAT: rdata_next = {7'h00, done_reg}; // [RULE11]
      default:        rdata_next = 8'h00;
    endcase
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
  end
endmodule // svt_tune_cal

//--- verification/svt_tune_cal_properties.sv
`timescale 1ns/1ps
// ------------
// tune checker
// ------------
module svt_tune_cal_properties #(
  parameter BASE_CYC = 1
) (
  // clock and reset
  input wire       clk_sys,
  input wire       reset,
  // register port
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire [7:0] reg_wdata,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // synthesizer side
  input wire       osc_too_fast,
  input wire [6:0] oscillator_tuning_word,
  input wire       synth_reset
);
  wire wt = reg_wr && reg_addr == 8'h59;
  wire wh = reg_wr && reg_addr == 8'h5c;
  wire wc = reg_wr && reg_addr == 8'h5d;
  wire rt = reg_rd && reg_addr == 8'h59;
  wire rc = reg_rd && reg_addr == 8'h5d;
  wire rs = reg_rd && reg_addr == 8'h5e;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_hold; wh |=> synth_reset == $past(reg_wdata[0]); endproperty
  a_hold: assert property (p_hold) else $error("hold output wrong");
  property p_sync; $changed(synth_reset) |-> $past(wh); endproperty
  a_sync: assert property (p_sync) else $error("hold moved alone");
  property p_trsv; rt |=> reg_rdata[7] == 1'b0; endproperty
  a_trsv: assert property (p_trsv) else $error("tune bit7 set");
  property p_srsv; rs |=> reg_rdata[7:1] == 7'h00; endproperty
  a_srsv: assert property (p_srsv) else $error("status upper set");
  property p_dclr; wh && reg_wdata[0] ##1 !wh ##1 rs |=> !reg_rdata[0]; endproperty
  a_dclr: assert property (p_dclr) else $error("done not cleared");
  property p_load; wt && synth_reset |=> ##1 oscillator_tuning_word == $past(reg_wdata[6:0], 2);
  endproperty
  a_load: assert property (p_load) else $error("tune not loaded");
  property p_back; wt && synth_reset ##2 rt |=> reg_rdata[6:0] == $past(reg_wdata[6:0], 3);
  endproperty
  a_back: assert property (p_back) else $error("tune readback");
  property p_ctrl; wc ##2 rc |=> reg_rdata == $past(reg_wdata, 3); endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl readback");
endmodule // svt_tune_cal_properties
bind svt_tune_cal svt_tune_cal_properties #(.BASE_CYC(BASE_CYC)) u_props (.clk_sys(clk_sys),
  .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .osc_too_fast(osc_too_fast),
  .oscillator_tuning_word(oscillator_tuning_word), .synth_reset(synth_reset));

//--- verification/tb_svt_tune_cal.sv
`timescale 1ns/1ps
// ----------
// tune bench
// ----------
module tb_svt_tune_cal;
  logic       clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       osc_too_fast, synth_reset;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
  logic [6:0] oscillator_tuning_word;
  int         n_mismatch = 0, checks_done = 0, cyc = 0, n4, n5;
  svt_tune_cal #(.BASE_CYC(1)) DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .osc_too_fast(osc_too_fast), .oscillator_tuning_word(oscillator_tuning_word),
    .synth_reset(synth_reset));
  initial forever #25 clk_sys = ~clk_sys;
  // oscillator runs fast above word 0x35
  always @* osc_too_fast = oscillator_tuning_word > 7'h35;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  task end_of_test;
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task check(string name, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1 reg_wr = 1'b0;
  endtask
  task rd(logic [7:0] a);
    @(posedge clk_sys);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1 reg_rd = 1'b0;
    rd_val = reg_rdata;
  endtask
  task t_reset;
    logic [7:0] a[5] = '{8'h59, 8'h5c, 8'h5d, 8'h5e, 8'h5a};
    logic [7:0] e[5] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rd(a[i]);
      check("reset value", rd_val, e[i]);
    end
  endtask
  task t_skip;
    wr(8'h5c, 8'h01);
    wr(8'h5d, 8'h40);
    wr(8'h5c, 8'h00);
    rd(8'h5e);
    check("skip done", rd_val, 8'h01);
    wr(8'h5c, 8'h01);
    check("hold pin", {7'h00, synth_reset}, 8'h01);
    rd(8'h5e);
    check("done cleared", rd_val, 8'h00);
  endtask
  task t_direct;
    wr(8'h59, 8'h2b);
    rd(8'h59);
    check("tune readback", rd_val, 8'h2b);
    check("tune pin", {1'b0, oscillator_tuning_word}, 8'h2b);
  endtask
  task t_cal(logic [7:0] ctrl, output int n);
    wr(8'h5c, 8'h01);
    wr(8'h5d, ctrl);
    rd(8'h5d);
    check("ctrl readback", rd_val, ctrl);
    wr(8'h5c, 8'h00);
    n = cyc;
    repeat (600) begin
      rd(8'h5e);
      if (rd_val[0] === 1'b1) break;
    end
    n = cyc - n;
    check("cal done", rd_val, 8'h01);
    rd(8'h59);
    check("cal word", rd_val, 8'h35);
    check("cal pin", {1'b0, oscillator_tuning_word}, 8'h35);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 reset = 1'b0;
    t_reset;
    t_skip;
    t_direct;
    t_cal(8'h41, n4);
    t_cal(8'h51, n5);
    check("settle longer", {7'h00, n5 > n4 + 100}, 8'h01);
    end_of_test;
  end
endmodule // tb_svt_tune_cal
